// ==== logic/sbh_bus_if.sv ====
/*
  Bus wires between one master end and one slave end.
  Assumes the testbench drives clk and rst into the interface.
*/
`timescale 1ns/1ns
interface sbh_bus_if;
  import sbh_pkg::*;
  logic                 clk;
  logic                 rst;
  logic                 cyc;
  logic                 stb;
  logic                 we;
  logic [SBH_ADR_W-1:0] adr;
  logic [SBH_DAT_W-1:0] dat_m2s;
  logic [SBH_SEL_W-1:0] sel;
  logic [SBH_DAT_W-1:0] dat_s2m;
  logic                 ack;
  logic                 err;
  logic                 rty;

  modport master (input clk, rst, ack, err, rty, dat_s2m,
                  output cyc, stb, we, adr, dat_m2s, sel);
  modport slave  (input clk, rst, cyc, stb, we, adr, dat_m2s, sel,
                  output ack, err, rty, dat_s2m);
endinterface

// ==== logic/sbh_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module sbh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out  = mem_ff[rd_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  //////////////////////////////////////////////////////////////////////////
  // Pointers and storage; the array itself needs no reset
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_in;
    end
    if (rst_in) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== logic/sbh_master.sv ====
/*
  Bus master end: takes requests from a FIFO, runs one strobe per request and one more per retry.
  Assumes a slave end on the interface and a request source that honours ready.
*/
`timescale 1ns/1ns
module sbh_master
  import sbh_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = SBH_FIFO_DEPTH
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  sbh_bus_if.master                 bus,
  input  wire logic                 req_valid_in,
  output logic                      req_ready_out,
  input  wire logic [1:0]           req_op_in,
  input  wire logic [SBH_ADR_W-1:0] req_adr_in,
  input  wire logic [SBH_DAT_W-1:0] req_dat_in,
  input  wire logic [SBH_SEL_W-1:0] req_sel_in,
  output logic                      rsp_valid_out,
  output logic      [1:0]           rsp_term_out,
  output logic      [SBH_DAT_W-1:0] rsp_dat_out,
  output logic                      busy_out
);
  import sbh_pkg::*;

  typedef struct packed {
    sbh_state_t            state;
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [SBH_ADR_W-1:0]  adr;
    logic [SBH_DAT_W-1:0]  dat;
    logic [SBH_SEL_W-1:0]  sel;
    logic [1:0]            op;
    logic [SBH_RETRY_W-1:0] wait_cnt;
    logic                  rsp_valid;
    logic [1:0]            rsp_term;
    logic [SBH_DAT_W-1:0]  rsp_dat;
  } sbh_mst_t;

  sbh_mst_t                 st_ff;
  sbh_mst_t                 nxt_st;
  logic                     q_valid;
  logic                     q_ready;
  logic [SBH_REQ_W-1:0]     q_data;
  logic                     term;
  logic [1:0]               q_op;
  logic [SBH_ADR_W-1:0]     q_adr;
  logic [SBH_DAT_W-1:0]     q_dat;
  logic [SBH_SEL_W-1:0]     q_sel;

  //////////////////////////////////////////////////////////////////////////
  // Request queue; its ready stalls the request source when full
  // Request word, high to low: operation, address, write data, byte selects
  sbh_fifo #(
    .WIDTH (SBH_REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_req_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (req_valid_in),
    .in_ready_out  (req_ready_out),
    .in_data_in    ({req_op_in, req_adr_in, req_dat_in, req_sel_in}),
    .out_valid_out (q_valid),
    .out_ready_in  (q_ready),
    .out_data_out  (q_data)
  );

  // Any termination ends the strobe; ack tied high still works
  assign term    = bus.ack | bus.err | bus.rty;
  assign q_ready = (st_ff.state == SBH_ST_IDLE);

  // Head of the queue split into its fields; only read while idle,
  // the struct keeps its own copy for the whole strobe and any retry
  assign q_op  = q_data[SBH_REQ_W-1 -: 2];
  assign q_adr = q_data[SBH_DAT_W+SBH_SEL_W +: SBH_ADR_W];
  assign q_dat = q_data[SBH_SEL_W +: SBH_DAT_W];
  assign q_sel = q_data[SBH_SEL_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Bus outputs come straight from flops, no gating after them
  assign bus.cyc     = st_ff.cyc;
  assign bus.stb     = st_ff.stb;
  // Qualifiers hold their last value outside a strobe; slaves must ignore them then
  assign bus.we      = st_ff.we;
  assign bus.adr     = st_ff.adr;
  assign bus.dat_m2s = st_ff.dat;
  assign bus.sel     = st_ff.sel;
  assign rsp_valid_out = st_ff.rsp_valid;
  assign rsp_term_out  = st_ff.rsp_term;
  assign rsp_dat_out   = st_ff.rsp_dat;
  assign busy_out      = st_ff.cyc;

  //////////////////////////////////////////////////////////////////////////
  // Termination policy of this master, for whoever integrates it:
  //   acknowledge - the request is done; read data is captured at that edge
  //   error       - the request is dropped and reported with an error code
  //   retry       - nothing is reported; the same request is strobed again
  //                 after a fixed backoff, so a slave that stays busy
  //                 stalls the whole queue behind it for as long as it stays busy
  // Events run as a read-shaped cycle with address, selects and write
  // enable zeroed; a slave that needs a bare strobe must not rely on cycle
  // being low, since cycle always brackets the strobe here.
  // A longer backoff frees the bus for others but delays the retried request.

  // Next state: one strobe per request, retry after a short backoff
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    unique case (st_ff.state)
      SBH_ST_IDLE: begin
        if (q_valid) begin
          nxt_st.op  = q_op;
          nxt_st.adr = q_adr;
          nxt_st.dat = q_dat;
          nxt_st.sel = q_sel;
          nxt_st.we  = (q_op == SBH_OP_WRITE);
          // Event carries no address phase meaning; zeroed to keep it clean
          if (q_op == SBH_OP_EVENT) begin
            nxt_st.we  = 1'b0;
            nxt_st.adr = '0;
            nxt_st.sel = '0;
          end
          nxt_st.cyc   = 1'b1;
          nxt_st.stb   = 1'b1;
          nxt_st.state = SBH_ST_STB;
        end
      end

      SBH_ST_STB: begin
        // Terminations are sampled only here, at the edge that ends the strobe
        // Read data is taken on every termination; only acknowledge makes it matter
        if (term) begin
          nxt_st.stb       = 1'b0;
          nxt_st.cyc       = 1'b0;
          nxt_st.rsp_dat   = bus.dat_s2m;
          if (bus.ack) begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_term  = SBH_TERM_ACK;
            nxt_st.state     = SBH_ST_IDLE;
          end else if (bus.err) begin
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_term  = SBH_TERM_ERR;
            nxt_st.state     = SBH_ST_IDLE;
          end else begin
            nxt_st.wait_cnt = SBH_RETRY_W'(SBH_RETRY_WAIT);
            nxt_st.state    = SBH_ST_WAIT;
          end
        end
      end

      SBH_ST_WAIT: begin
        // Retry the same request after the backoff; no response until then
        if (st_ff.wait_cnt == '0) begin
          nxt_st.cyc   = 1'b1;
          nxt_st.stb   = 1'b1;
          nxt_st.state = SBH_ST_STB;
        end else begin
          nxt_st.wait_cnt = st_ff.wait_cnt - 1'b1;
        end
      end

      // Code 2'b10 is unused; fall back to idle rather than lock up
      default: begin
        nxt_st.state = SBH_ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; reset is synchronous and wins at any time
  // A request cut by reset is lost without an answer; the request source
  // must offer again whatever it still needs after reset is released
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ==== logic/sbh_pkg.sv ====
/*
  Shared constants and types for the bus handshake master and slave ends.
  Assumes one rising-edge clock and one synchronous active-high reset for both ends.
*/
package sbh_pkg;
  localparam int unsigned SBH_ADR_W      = 8;
  localparam int unsigned SBH_DAT_W      = 32;
  localparam int unsigned SBH_SEL_W      = SBH_DAT_W / 8;
  localparam int unsigned SBH_FIFO_DEPTH = 32;
  localparam int unsigned SBH_MEM_WORDS  = 16;
  localparam int unsigned SBH_MEM_AW     = 4;
  localparam int unsigned SBH_RETRY_WAIT = 4;
  localparam int unsigned SBH_RETRY_W    = 3;

  // Master operation kind, taken from the request word
  typedef enum logic [1:0] {
    SBH_OP_READ  = 2'h0,
    SBH_OP_WRITE = 2'h1,
    SBH_OP_EVENT = 2'h2
  } sbh_op_t;

  // Termination seen by the master
  typedef enum logic [1:0] {
    SBH_TERM_ACK = 2'h0,
    SBH_TERM_ERR = 2'h1,
    SBH_TERM_RTY = 2'h2
  } sbh_term_t;

  // Master states, Gray coded along idle -> strobe -> backoff
  typedef enum logic [1:0] {
    SBH_ST_IDLE = 2'b00,
    SBH_ST_STB  = 2'b01,
    SBH_ST_WAIT = 2'b11
  } sbh_state_t;

  localparam int unsigned SBH_REQ_W = 2 + SBH_ADR_W + SBH_DAT_W + SBH_SEL_W;
endpackage

// ==== logic/sbh_slave.sv ====
/*
  Bus slave end: small word memory with combinational terminations.
  Assumes a master end on the interface; user inputs force error or retry.
*/
`timescale 1ns/1ns
module sbh_slave
  import sbh_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  sbh_bus_if.slave                  bus,
  input  wire logic                 busy_in,
  input  wire logic                 fault_in,
  output logic                      event_out,
  output logic      [SBH_DAT_W-1:0] last_wr_out
);
  import sbh_pkg::*;

  typedef struct packed {
    logic [SBH_MEM_WORDS-1:0][SBH_DAT_W-1:0] mem;
    logic                                    evt;
    logic [SBH_DAT_W-1:0]                    last_wr;
  } sbh_slv_t;

  sbh_slv_t               st_ff;
  sbh_slv_t               nxt_st;
  logic                   sel_err;
  logic                   sel_rty;
  logic [SBH_MEM_AW-1:0]  idx;

  assign idx = bus.adr[SBH_MEM_AW-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Terminations follow strobe with no clock; priority keeps one at a time
  assign sel_rty  = bus.stb & busy_in;
  assign sel_err  = bus.stb & ~busy_in & fault_in;
  assign bus.rty  = sel_rty;
  assign bus.err  = sel_err;
  assign bus.ack  = bus.stb & ~busy_in & ~fault_in;
  // Read data is driven only while a termination is up
  assign bus.dat_s2m = (bus.stb & bus.cyc) ? st_ff.mem[idx] : '0;
  assign event_out   = st_ff.evt;
  assign last_wr_out = st_ff.last_wr;

  //////////////////////////////////////////////////////////////////////////
  // Writes land on acknowledge with byte selects; an acknowledged strobe without cycle is an event
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.evt = bus.stb & ~bus.cyc & bus.ack;
    if (bus.ack & bus.cyc & bus.we) begin
      for (int b = 0; b < SBH_SEL_W; b++) begin
        if (bus.sel[b]) begin
          nxt_st.mem[idx][b*8 +: 8] = bus.dat_m2s[b*8 +: 8];
        end
      end
      nxt_st.last_wr = bus.dat_m2s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ==== tb/sbh_bus_checker.sv ====
/*
  Timing checks on the bus wires between the master and slave ends.
  Assumes one clock and the synchronous active-high reset of the interface.
*/
`timescale 1ns/1ns
module sbh_bus_checker
  import sbh_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 cyc,
  input wire logic                 stb,
  input wire logic [SBH_DAT_W-1:0] dat_s2m,
  input wire logic                 ack,
  input wire logic                 err,
  input wire logic                 rty
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Retry answer, then the quiet span the master owes the slave
  sequence s_retry;
    stb && rty;
  endsequence
  sequence s_quiet;
    !stb [*4];
  endsequence
  a_reset_idle: assert property ($fell(rst) |-> !stb && !cyc)
    else $error("strobe or cycle high after reset");
  a_term_onehot: assert property ($onehot0({ack, err, rty}))
    else $error("two terminations at once");
  a_term_tracks: assert property (stb == (ack || err || rty))
    else $error("termination not following strobe");
  a_stb_drops: assert property (stb |=> !stb)
    else $error("strobe held past its termination");
  a_cycle_covers: assert property (stb |-> cyc)
    else $error("strobe outside a cycle");
  a_read_qual: assert property (!(ack || err || rty) |-> dat_s2m == 32'h0)
    else $error("read data driven without termination");
  a_retry_wait: assert property (s_retry |=> s_quiet)
    else $error("retry not followed by backoff");
  a_err_close: assert property (stb && err |=> !cyc)
    else $error("cycle kept open after error");
  a_ack_close: assert property (stb && ack |=> !cyc)
    else $error("cycle kept open after acknowledge");
endmodule

// ==== tb/soc_bus_handshake_tb.sv ====
/*
  Self-checking bench: master and slave ends joined by the bus interface.
  Assumes the slave memory clears on reset and error writes are dropped.
*/
`timescale 1ns/1ns
module soc_bus_handshake_tb;
  import sbh_pkg::*;
  logic                 clk_in, rst_in, req_valid, req_ready, rsp_valid, busy, fault, mbusy;
  logic [SBH_DAT_W-1:0] last_wr;
  logic [1:0]           req_op, rsp_term;
  logic [SBH_ADR_W-1:0] req_adr;
  logic [SBH_DAT_W-1:0] req_dat, rsp_dat;
  logic [SBH_SEL_W-1:0] req_sel;
  logic [SBH_DAT_W-1:0] mem [SBH_MEM_WORDS];
  logic [1:0]           q_term [$];
  logic [SBH_DAT_W-1:0] q_dat [$];
  int                   q_rd [$];
  bit                   ok, hold;
  int                   err_total, cmp_count, n, i;
  sbh_bus_if bus ();
  assign bus.clk = clk_in;
  assign bus.rst = rst_in;
  sbh_master i_sbh_master (.clk_in(clk_in), .rst_in(rst_in), .bus(bus),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_op_in(req_op),
    .req_adr_in(req_adr), .req_dat_in(req_dat), .req_sel_in(req_sel),
    .rsp_valid_out(rsp_valid), .rsp_term_out(rsp_term), .rsp_dat_out(rsp_dat),
    .busy_out(mbusy));
  sbh_slave i_sbh_slave (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .busy_in(busy),
    .fault_in(fault), .event_out(), .last_wr_out(last_wr));
  sbh_bus_checker i_sbh_bus_checker (.clk(bus.clk), .rst(bus.rst), .cyc(bus.cyc),
    .stb(bus.stb), .dat_s2m(bus.dat_s2m), .ack(bus.ack), .err(bus.err), .rty(bus.rty));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Model reset: memory and pending answers gone
  task automatic clr();
    foreach (mem[k]) mem[k] = 32'h0;
    q_term.delete();
    q_dat.delete();
    q_rd.delete();
  endtask
  // One random request offered at a falling edge; the model follows it in order
  task automatic put(output bit acc);
    logic [1:0] o;
    logic [3:0] s;
    o = 2'($urandom_range(2));
    s = (o == 2'h0) ? 4'hf : 4'($urandom);
    busy = hold | ($urandom_range(3) == 0);
    acc = req_ready;
    req_valid = acc;
    if (acc) begin
      {req_op, req_adr, req_dat, req_sel} = {o, 8'($urandom), $urandom, s};
      q_term.push_back({1'b0, fault});
      q_rd.push_back(fault ? 0 : (o == 2'h0) ? 1 : (o == 2'h1) ? 2 : 0);
      q_dat.push_back((o == 2'h1) ? req_dat : mem[req_adr[3:0]]);
      if (o == 2'h1 && !fault)
        for (int b = 0; b < 4; b++) if (s[b]) mem[req_adr[3:0]][8*b+:8] = req_dat[8*b+:8];
    end
    @(negedge clk_in);
  endtask
  // Waits for the master to answer everything queued; bounded
  task automatic drain();
    req_valid = 1'b0;
    hold = 1'b0;
    busy = 1'b0;
    repeat (3000) if (q_term.size() != 0) @(negedge clk_in);
    check("pending answers", 0, q_term.size());
    check("busy after drain", 0, mbusy);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Answers are compared in request order, once per pulse
  always @(negedge clk_in) begin
    if (rsp_valid === 1'b1) begin
      if (q_term.size() == 0) check("spare answer", 0, 1);
      else begin
        check("termination", q_term[0], rsp_term);
        if (q_rd[0] == 1) check("read data", q_dat[0], rsp_dat);
        else if (q_rd[0] == 2) check("last write", q_dat[0], last_wr);
        void'(q_term.pop_front());
        void'(q_dat.pop_front());
        void'(q_rd.pop_front());
      end
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // A hang ends the run through the same verdict
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  initial begin
    {rst_in, req_valid, req_op, req_adr, req_dat, req_sel, busy, fault, hold} = '0;
    rst_in = 1'b1;
    void'($urandom(32'h4f23));
    clr();
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    check("strobe after reset", 0, bus.stb);
    // Back-to-back traffic with random retries
    for (i = 0; i < 60; i++) do put(ok); while (!ok);
    drain();
    // Fill the queue behind a busy slave until refused, then drain
    hold = 1'b1;
    ok = 1'b1;
    for (n = 0; ok; n++) put(ok);
    check("accepted before refusal", SBH_FIFO_DEPTH + 1, n - 1);
    check("ready while full", 0, req_ready);
    drain();
    // Faulty slave: every request ends in error
    fault = 1'b1;
    for (i = 0; i < 8; i++) do put(ok); while (!ok);
    drain();
    fault = 1'b0;
    // Reset during the backoff of a retried request, with cycle already low
    hold = 1'b1;
    put(ok);
    req_valid = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    hold = 1'b0;
    clr();
    check("cycle after mid reset", 0, bus.cyc);
    @(negedge clk_in);
    for (i = 0; i < 40; i++) do put(ok); while (!ok);
    drain();
    final_report();
  end
endmodule
